// *** rtl/gw_pkg.sv ***
// gw_pkg: constants shared by the wake monitor and external interrupt block.
// Assumes a 100 MHz system clock and 32-bit APB register access.
package gw_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int PIN_COUNT = 24;
    localparam int EXT_COUNT = 4;
    localparam int SEL_W     = 5;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_PIN_WAKE_ENABLE  = 8'h00;
    localparam logic [7:0] OFS_WAKE_SELECT      = 8'h04;
    localparam logic [7:0] OFS_WAKE_FILTER      = 8'h08;
    localparam logic [7:0] OFS_EXT_INT_CONFIG_A = 8'h0C;
    localparam logic [7:0] OFS_EXT_INT_PENDING  = 8'h1C;
    localparam logic [7:0] OFS_EXT_INT_C_SELECT = 8'h20;
    localparam logic [7:0] OFS_EXT_INT_D_SELECT = 8'h24;
    localparam logic [7:0] OFS_DEBUG_CONFIG     = 8'h28;
    localparam logic [7:0] OFS_DEBUG_STATUS     = 8'h2C;
    localparam logic [7:0] OFS_WAKE_STATUS      = 8'h30;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    // wake source order, shared by select and filter registers
    localparam int SRC_PINS = 0;
    localparam int SRC_SC1  = 1;
    localparam int SRC_SC2  = 2;
    localparam int SRC_EXTD = 3;
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_FILT_BIT = 3;
    localparam int DBGCFG_DEBUG_DISABLE = 0;
    localparam int DBGCFG_EXT_REG_EN    = 1;
    localparam int DBGCFG_TIMER_REMAP   = 2;
    localparam int DBGST_FORCED = 0;
    localparam int DBGST_SWIRE  = 1;
    localparam int DBGST_BOOT   = 2;

    // ------------------------------------------------------------
    // pin indices (port A 0..7, B 8..15, C 16..23)
    // ------------------------------------------------------------
    localparam int PIN_IRQ_A   = 8;
    localparam int PIN_IRQ_B   = 14;
    localparam int PIN_BOOT    = 5;
    localparam int PIN_REG_EN  = 7;
    localparam int PIN_JTAG_RESET_IN    = 16;
    localparam int PIN_JDO     = 18;
    localparam int PIN_JDI     = 19;
    localparam int PIN_JMS     = 20;
    localparam int PIN_TMR_DEF = 0;
    localparam int PIN_TMR_REM = 9;
    localparam int TMR_CHANS   = 4;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [2:0] RST_DEBUG_CONFIG = 3'h2;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS         = 10;
    localparam int EXT_FILT_NS    = 450;
    localparam int EXT_FILT_CYC   = (EXT_FILT_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAKE_SAMPLES   = 3;

    // ------------------------------------------------------------
    // trigger modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        GW_TRIG_OFF  = 3'h0,
        GW_TRIG_RISE = 3'h1,
        GW_TRIG_FALL = 3'h2,
        GW_TRIG_BOTH = 3'h3,
        GW_TRIG_HIGH = 3'h4,
        GW_TRIG_LOW  = 3'h5
    } gw_trig_t;

endpackage

// *** rtl/gw_stable_filter.sv ***
// gw_stable_filter: passes a new input value only after it was seen on
// a run of consecutive samples. Used for wake and interrupt filtering.
// Assumes din and sampleEn are already in the clk domain.
`timescale 1ns/1ps
module gw_stable_filter #(
    parameter int RUN = 3
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic sampleEn,
    input  wire logic din,
    output logic      dout
);

    localparam int CW = $clog2(RUN + 1);
    localparam logic [CW-1:0] LAST = CW'(RUN - 1);

    logic [CW-1:0] runCount;

    // ------------------------------------------------------------
    // run counter; any sample equal to dout restarts the run
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            runCount <= '0;
            dout     <= 1'b0;
        end else if (sampleEn) begin
            if (din == dout) begin
                runCount <= '0;
            end else if (runCount == LAST) begin
                runCount <= '0;
                dout     <= din;   // run complete, accept value
            end else begin
                runCount <= runCount + CW'(1);
            end
        end
    end

endmodule

// *** rtl/gw_wake_irq.sv ***
// gw_wake_irq: deep sleep wake monitor, four external interrupts with
// pending flags, debug configuration/status and debug pin overrides.
// Assumes pins, serial activity and the RC clock are asynchronous, while
// sleep control, analog mask and debugger state come from clk logic.
//
// Summary of operation
// - per-pin wake enable; enabled change wakes
// - pin levels captured on sleep entry
// - any difference from reference is wake
// - record pin wake, not which pin
// - filter enable per wake source
// - RC-clock samples, three equal differing samples
// - pin wake needs pin source select
// - analog pins never wake
// - four interrupts, one request line each
// - interrupts use normal input path
// - trigger mode codes zero to five
// - per-interrupt filter, 450 ns minimum
// - pending flags, write one clears
// - level interrupt re-pends while active
// - A, B fixed pins; C, D selectable
// - select 0..23 maps ports A, B, C
// - debug status: two debugger flags, boot
// - debug config holds debugger disable
// - JTAG forces pin directions and pull-ups
// - serial wire data pin debugger-directed
// - boot pin pulled up, regulator open-drain
// - timer two channels default or remapped
// - analog input reads as logic high
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module gw_wake_irq
    import gw_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [PIN_COUNT-1:0] pinIn,
    input  wire logic [PIN_COUNT-1:0] analogMask,
    input  wire logic                 serialCtrlOneAct,
    input  wire logic                 serialCtrlTwoAct,
    input  wire logic                 rcClk,
    input  wire logic                 sleepEntry,
    input  wire logic                 deepSleep,
    input  wire logic                 jtagActive,
    input  wire logic                 swActive,
    input  wire logic                 swDataDrive,
    output logic                      wakeRequest,
    output logic      [EXT_COUNT-1:0] extIntRequest,
    output logic      [PIN_COUNT-1:0] pinOverride,
    output logic      [PIN_COUNT-1:0] pinOverrideOut,
    output logic      [PIN_COUNT-1:0] pinOverridePullUp,
    output logic      [PIN_COUNT-1:0] pinOverrideOpenDrain,
    output logic      [PIN_COUNT-1:0] timerTwoPins
);

    // ------------------------------------------------------------
    // synchronisers for asynchronous inputs
    // ------------------------------------------------------------
    logic [PIN_COUNT+2:0] syncA;
    logic [PIN_COUNT+2:0] syncB;

    // first stage feeds only the second stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            syncA <= '0;
            syncB <= '0;
        end else begin
            syncA <= {rcClk, serialCtrlTwoAct, serialCtrlOneAct, pinIn};
            syncB <= syncA;
        end
    end

    logic [PIN_COUNT-1:0] pinLevel;
    logic                 sc1Level;
    logic                 sc2Level;
    logic                 rcLevel;
    logic                 rcPrev;
    logic                 rcTick;

    // analog pins read high, so they never differ or give edges; a high-level trigger still fires on them
    assign pinLevel = syncB[PIN_COUNT-1:0] | analogMask;
    assign sc1Level = syncB[PIN_COUNT];
    assign sc2Level = syncB[PIN_COUNT+1];
    assign rcLevel  = syncB[PIN_COUNT+2];
    assign rcTick   = rcLevel & ~rcPrev;

    // rising edge of the slow RC clock gives the filter sample
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rcPrev <= 1'b0;
        end else begin
            rcPrev <= rcLevel;
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    logic [PIN_COUNT-1:0] pinWakeEnable;
    logic [EXT_COUNT-1:0] wakeSelect;
    logic [EXT_COUNT-1:0] wakeFilterEnable;
    logic [3:0]           extIntConfig [EXT_COUNT];
    logic [EXT_COUNT-1:0] extIntPendingFlags;
    logic [SEL_W-1:0]     extIntCSelect;
    logic [SEL_W-1:0]     extIntDSelect;
    logic [2:0]           debugConfig;
    logic                 wakeByPins;
    logic                 bootPinCaptured;

    logic       accessCycle;
    logic       writeHit;
    logic [5:0] wordIndex;
    logic [5:0] cfgBase;

    assign accessCycle = psel & penable & pready;
    assign writeHit    = accessCycle & pwrite;
    assign wordIndex   = paddr[7:2];
    assign cfgBase     = OFS_EXT_INT_CONFIG_A[7:2];

    // control registers written in the access phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinWakeEnable    <= '0;
            wakeSelect       <= '0;
            wakeFilterEnable <= '0;
            extIntCSelect    <= '0;
            extIntDSelect    <= '0;
            debugConfig      <= RST_DEBUG_CONFIG;
            for (int i = 0; i < EXT_COUNT; i++) begin
                extIntConfig[i] <= '0;
            end
        end else if (writeHit) begin
            unique case (paddr)
                OFS_PIN_WAKE_ENABLE:  pinWakeEnable    <= pwdata[PIN_COUNT-1:0];
                OFS_WAKE_SELECT:      wakeSelect       <= pwdata[EXT_COUNT-1:0];
                OFS_WAKE_FILTER:      wakeFilterEnable <= pwdata[EXT_COUNT-1:0];
                OFS_EXT_INT_C_SELECT: extIntCSelect    <= pwdata[SEL_W-1:0];
                OFS_EXT_INT_D_SELECT: extIntDSelect    <= pwdata[SEL_W-1:0];
                OFS_DEBUG_CONFIG:     debugConfig      <= pwdata[2:0];
                default: begin
                    for (int i = 0; i < EXT_COUNT; i++) begin
                        if (wordIndex == cfgBase + 6'(i)) begin
                            extIntConfig[i] <= pwdata[3:0];
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // APB answer: ready in the first access cycle, data from setup
    // ------------------------------------------------------------
    logic [31:0] next_prdata;
    logic        next_error;

    always_comb begin
        next_prdata = 32'h0000_0000;
        next_error  = 1'b0;
        unique case (paddr)
            OFS_PIN_WAKE_ENABLE:  next_prdata[PIN_COUNT-1:0] = pinWakeEnable;
            OFS_WAKE_SELECT:      next_prdata[EXT_COUNT-1:0] = wakeSelect;
            OFS_WAKE_FILTER:      next_prdata[EXT_COUNT-1:0] = wakeFilterEnable;
            OFS_EXT_INT_PENDING:  next_prdata[EXT_COUNT-1:0] = extIntPendingFlags;
            OFS_EXT_INT_C_SELECT: next_prdata[SEL_W-1:0]     = extIntCSelect;
            OFS_EXT_INT_D_SELECT: next_prdata[SEL_W-1:0]     = extIntDSelect;
            OFS_DEBUG_CONFIG:     next_prdata[2:0]           = debugConfig;
            OFS_DEBUG_STATUS: begin
                next_prdata[DBGST_FORCED] = jtagActive & ~debugConfig[DBGCFG_DEBUG_DISABLE];
                next_prdata[DBGST_SWIRE]  = swActive & ~debugConfig[DBGCFG_DEBUG_DISABLE];
                next_prdata[DBGST_BOOT]   = bootPinCaptured;
                next_error                = pwrite;            // read-only
            end
            OFS_WAKE_STATUS:      next_prdata[0]             = wakeByPins;
            default: begin
                next_error = 1'b1;
                for (int i = 0; i < EXT_COUNT; i++) begin
                    if (wordIndex == cfgBase + 6'(i) && paddr[1:0] == 2'h0) begin
                        next_prdata[3:0] = extIntConfig[i];
                        next_error       = 1'b0;
                    end
                end
            end
        endcase
    end

    // one wait-free access phase; unmapped addresses answer with an error
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & next_error;
            prdata  <= (psel & ~penable & ~pwrite) ? next_prdata : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // external interrupt sources and detection
    // ------------------------------------------------------------
    logic [EXT_COUNT-1:0] extRaw;
    logic [EXT_COUNT-1:0] extFilt;
    logic [EXT_COUNT-1:0] extLevel;
    logic [EXT_COUNT-1:0] extPrev;
    logic [EXT_COUNT-1:0] extSet;
    logic [EXT_COUNT-1:0] extClear;

    // selection beyond 23 reads as idle high, the analog level
    assign extRaw[0] = pinLevel[PIN_IRQ_A];
    assign extRaw[1] = pinLevel[PIN_IRQ_B];
    assign extRaw[2] = (32'(extIntCSelect) < PIN_COUNT) ? pinLevel[extIntCSelect] : 1'b1;
    assign extRaw[3] = (32'(extIntDSelect) < PIN_COUNT) ? pinLevel[extIntDSelect] : 1'b1;

    generate
        for (genvar g = 0; g < EXT_COUNT; g++) begin : gExt
            gw_stable_filter #(
                .RUN      (EXT_FILT_CYC)
            ) uFilt (
                .clk      (clk),
                .rst      (rst),
                .sampleEn (1'b1),
                .din      (extRaw[g]),
                .dout     (extFilt[g])
            );
            // filtered path rejects pulses shorter than the filter run
            assign extLevel[g] = extIntConfig[g][CFG_FILT_BIT] ? extFilt[g] : extRaw[g];
        end
    endgenerate

    // previous level for edge detection
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            extPrev <= '0;
        end else begin
            extPrev <= extLevel;
        end
    end

    // trigger decode per source
    always_comb begin
        extSet = '0;
        for (int i = 0; i < EXT_COUNT; i++) begin
            unique case (extIntConfig[i][2:0])
                GW_TRIG_RISE: extSet[i] = extLevel[i] & ~extPrev[i];
                GW_TRIG_FALL: extSet[i] = ~extLevel[i] & extPrev[i];
                GW_TRIG_BOTH: extSet[i] = extLevel[i] ^ extPrev[i];
                GW_TRIG_HIGH: extSet[i] = extLevel[i];
                GW_TRIG_LOW:  extSet[i] = ~extLevel[i];
                default:      extSet[i] = 1'b0;           // off and unused codes
            endcase
        end
    end

    assign extClear = (writeHit && paddr == OFS_EXT_INT_PENDING) ? pwdata[EXT_COUNT-1:0] : '0;

    // set beats clear so a same-cycle event is kept
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            extIntPendingFlags <= '0;
        end else begin
            extIntPendingFlags <= (extIntPendingFlags & ~extClear) | extSet;
        end
    end

    // one request line per source, only while its mode is on
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            extIntRequest <= '0;
        end else begin
            for (int i = 0; i < EXT_COUNT; i++) begin
                extIntRequest[i] <= extIntPendingFlags[i] & (extIntConfig[i][2:0] != 3'h0);
            end
        end
    end

    // ------------------------------------------------------------
    // deep sleep wake monitor
    // ------------------------------------------------------------
    logic [PIN_COUNT-1:0] pinRef;
    logic                 sc1Ref;
    logic                 sc2Ref;
    logic                 extDRef;
    logic [EXT_COUNT-1:0] srcDiff;
    logic [EXT_COUNT-1:0] srcFilt;
    logic [EXT_COUNT-1:0] srcHit;

    // snapshot of every input on entry to sleep
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinRef  <= '1;
            sc1Ref  <= 1'b0;
            sc2Ref  <= 1'b0;
            extDRef <= 1'b1;
        end else if (sleepEntry) begin
            pinRef  <= pinLevel;
            sc1Ref  <= sc1Level;
            sc2Ref  <= sc2Level;
            extDRef <= extRaw[3];
        end
    end

    // no edge or level choice: any mismatch counts
    assign srcDiff[SRC_PINS] = |((pinLevel ^ pinRef) & pinWakeEnable);
    assign srcDiff[SRC_SC1]  = sc1Level ^ sc1Ref;
    assign srcDiff[SRC_SC2]  = sc2Level ^ sc2Ref;
    assign srcDiff[SRC_EXTD] = extRaw[3] ^ extDRef;

    // filters only advance on RC ticks and are untouched by sleep
    generate
        for (genvar w = 0; w < EXT_COUNT; w++) begin : gWake
            gw_stable_filter #(
                .RUN      (WAKE_SAMPLES)
            ) uWake (
                .clk      (clk),
                .rst      (rst),
                .sampleEn (rcTick),
                .din      (srcDiff[w]),
                .dout     (srcFilt[w])
            );
            assign srcHit[w] = wakeSelect[w] &
                (wakeFilterEnable[w] ? srcFilt[w] : srcDiff[w]);
        end
    endgenerate

    // wake is held until the next sleep entry; only the pin fact is kept
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wakeRequest <= 1'b0;
            wakeByPins  <= 1'b0;
        end else if (sleepEntry) begin
            wakeRequest <= 1'b0;
            wakeByPins  <= 1'b0;
        end else if (deepSleep) begin
            if (|srcHit) begin
                wakeRequest <= 1'b1;
            end
            if (srcHit[SRC_PINS]) begin
                wakeByPins <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // boot pin capture after reset release
    // ------------------------------------------------------------
    logic [2:0] bootPending;

    // the sampled level is only valid once the synchroniser has filled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bootPending     <= 3'h7;
            bootPinCaptured <= 1'b0;
        end else if (bootPending != 3'h0) begin
            bootPending     <= bootPending >> 1;
            if (bootPending == 3'h1) begin
                bootPinCaptured <= ~syncB[PIN_BOOT];
            end
        end
    end

    // ------------------------------------------------------------
    // forced pin functions
    // ------------------------------------------------------------
    logic dbgOn;
    logic jtagOn;
    logic swOn;

    assign dbgOn  = ~debugConfig[DBGCFG_DEBUG_DISABLE];
    assign jtagOn = dbgOn & jtagActive;
    assign swOn   = dbgOn & swActive & ~jtagActive;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // reset: boot pin pulled up, everything else released
            pinOverride          <= '0;
            pinOverrideOut       <= '0;
            pinOverridePullUp    <= '0;
            pinOverrideOpenDrain <= '0;
            pinOverride[PIN_BOOT]       <= 1'b1;
            pinOverridePullUp[PIN_BOOT] <= 1'b1;
        end else begin
            pinOverride          <= '0;
            pinOverrideOut       <= '0;
            pinOverridePullUp    <= '0;
            pinOverrideOpenDrain <= '0;
            if (bootPending != 3'h0) begin
                pinOverride[PIN_BOOT]       <= 1'b1;
                pinOverridePullUp[PIN_BOOT] <= 1'b1;
            end
            if (debugConfig[DBGCFG_EXT_REG_EN]) begin
                pinOverride[PIN_REG_EN]          <= 1'b1;
                pinOverrideOut[PIN_REG_EN]       <= 1'b1;
                pinOverrideOpenDrain[PIN_REG_EN] <= 1'b1;
            end
            if (jtagOn) begin
                pinOverride[PIN_JTAG_RESET_IN]       <= 1'b1;
                pinOverridePullUp[PIN_JTAG_RESET_IN] <= 1'b1;
                pinOverride[PIN_JDI]        <= 1'b1;
                pinOverridePullUp[PIN_JDI]  <= 1'b1;
                pinOverride[PIN_JMS]        <= 1'b1;
                pinOverridePullUp[PIN_JMS]  <= 1'b1;
                pinOverride[PIN_JDO]        <= 1'b1;
                pinOverrideOut[PIN_JDO]     <= 1'b1;
            end else if (swOn) begin
                pinOverride[PIN_JMS]    <= 1'b1;
                pinOverrideOut[PIN_JMS] <= swDataDrive;   // floating input otherwise
            end
        end
    end

    // timer two channel placement
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timerTwoPins <= '0;
        end else begin
            timerTwoPins <= '0;
            for (int i = 0; i < TMR_CHANS; i++) begin
                if (debugConfig[DBGCFG_TIMER_REMAP]) begin
                    timerTwoPins[PIN_TMR_REM + i] <= 1'b1;
                end else begin
                    timerTwoPins[PIN_TMR_DEF + i] <= 1'b1;
                end
            end
        end
    end

endmodule

// *** sim/gw_wake_irq_checker.sv ***
// checker: bus and output relations of the wake/irq block
// assumes it is bound onto the ports of gw_wake_irq
`timescale 1ns/1ps
module gw_wake_irq_checker
    import gw_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sleepEntry,
    input wire logic        deepSleep,
    input wire logic        wakeRequest,
    input wire logic [3:0]  extIntRequest,
    input wire logic [23:0] timerTwoPins
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_PREADY: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    AST_PRONE: assert property (pready |=> !pready) else $error("answer too long");
    AST_ERR: assert property (pslverr |-> pready) else $error("lone error");
    AST_CLRWAKE: assert property (sleepEntry |=> !wakeRequest)
        else $error("wake not cleared");
    AST_HOLD: assert property (wakeRequest && !sleepEntry |=> wakeRequest)
        else $error("wake dropped");
    AST_WAKESLP: assert property ($rose(wakeRequest) |-> $past(deepSleep))
        else $error("wake outside sleep");
    AST_EXTCLR: assert property ($fell(extIntRequest[2]) |->
        $past(psel && pwrite, 2) || $past(psel && pwrite, 3)) else $error("flag lost");
    AST_TMR: assert property (!$past(rst) |-> $countones(timerTwoPins) == 4)
        else $error("timer pins");
    cover property ($rose(wakeRequest));
    cover property ($rose(extIntRequest[2]));
    cover property (pslverr);
endmodule
bind gw_wake_irq gw_wake_irq_checker gw_wake_irq_checker_i (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
    .sleepEntry(sleepEntry), .deepSleep(deepSleep), .wakeRequest(wakeRequest),
    .extIntRequest(extIntRequest), .timerTwoPins(timerTwoPins));

// *** sim/gw_pins_model.sv ***
// partner: board levels on the pins and a free-running slow rc clock
// assumes the bench sets the wanted levels on lvl
`timescale 1ns/1ps
module gw_pins_model #(
    parameter int RC_HALF = 50
) (
    input  wire logic        clk,
    input  wire logic [23:0] lvl,
    output logic      [23:0] pinIn,
    output logic             rcClk
);
    int cnt = 0;
    initial pinIn = 24'h0;
    initial rcClk = 1'b0;
    // the oscillator never stops, so it is not gated by frames
    always @(posedge clk) begin
        pinIn <= lvl;
        cnt   <= (cnt == RC_HALF - 1) ? 0 : cnt + 1;
        if (cnt == 0) rcClk <= ~rcClk;
    end
endmodule

// *** sim/gw_wake_irq_test.sv ***
// bench: register, interrupt and wake scenarios over APB
// assumes gw_pins_model stands in for the board
`timescale 1ns/1ps
module gw_wake_irq_test
    import gw_pkg::*;
;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, sleepEntry = 0, deepSleep = 0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, wakeRequest, rcClk;
    logic [23:0] lvl = 24'h20, aMask = 24'h0, pinIn;
    logic [3:0] extIntRequest;
    int n_mismatch = 0, checks = 0;
    always #5 clk = ~clk;
    gw_wake_irq gw_wake_irq_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pinIn(pinIn), .analogMask(aMask), .serialCtrlOneAct(1'b0),
        .serialCtrlTwoAct(1'b0), .rcClk(rcClk), .sleepEntry(sleepEntry),
        .deepSleep(deepSleep), .jtagActive(1'b0), .swActive(1'b0), .swDataDrive(1'b0),
        .wakeRequest(wakeRequest), .extIntRequest(extIntRequest), .pinOverride(),
        .pinOverrideOut(), .pinOverridePullUp(), .pinOverrideOpenDrain(), .timerTwoPins());
    gw_pins_model gw_pins_model_i (.clk(clk), .lvl(lvl), .pinIn(pinIn), .rcClk(rcClk));
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one transfer; held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic t_regs;
        apb(1'b0, OFS_DEBUG_CONFIG, 32'h0); chk(rd, {29'h0, RST_DEBUG_CONFIG});
        apb(1'b0, 8'h34, 32'h0); chk(er, 1'b1);
        apb(1'b1, OFS_DEBUG_STATUS, 32'h7); chk(er, 1'b1);
        apb(1'b0, OFS_DEBUG_STATUS, 32'h0); chk(rd[2:0], 3'h0);
    endtask
    // every trigger code on a routed pin, then clear with the input held
    task automatic t_ext;
        logic idle;
        apb(1'b1, OFS_EXT_INT_CONFIG_A, 32'h1);
        lvl[PIN_IRQ_A] <= 1'b1;
        repeat (8) @(posedge clk); chk(extIntRequest[0], 1'b1);
        apb(1'b1, OFS_EXT_INT_C_SELECT, 32'h11);
        for (int m = 0; m < 6; m++) begin
            idle = (m == 2 || m == 5);
            lvl[17] <= idle;
            apb(1'b1, 8'h14, m);
            repeat (8) @(posedge clk);
            apb(1'b1, OFS_EXT_INT_PENDING, 32'h4);
            repeat (4) @(posedge clk); chk(extIntRequest[2], 1'b0);
            lvl[17] <= !idle;
            repeat (8) @(posedge clk); chk(extIntRequest[2], m != 0);
            apb(1'b1, OFS_EXT_INT_PENDING, 32'h4);
            repeat (4) @(posedge clk); chk(extIntRequest[2], m > 3);
        end
    endtask
    task automatic t_wake;
        apb(1'b1, OFS_PIN_WAKE_ENABLE, 32'h8);
        apb(1'b1, OFS_WAKE_SELECT, 32'h1);
        sleepEntry <= 1'b1; deepSleep <= 1'b1; @(posedge clk); sleepEntry <= 1'b0;
        lvl[4] <= 1'b1; repeat (8) @(posedge clk); chk(wakeRequest, 1'b0);
        lvl[3] <= 1'b1; repeat (8) @(posedge clk); chk(wakeRequest, 1'b1);
        apb(1'b0, OFS_WAKE_STATUS, 32'h0); chk(rd, 32'h1);
        aMask[3] <= 1'b1; sleepEntry <= 1'b1; @(posedge clk); sleepEntry <= 1'b0;
        lvl[3] <= 1'b0; repeat (8) @(posedge clk); chk(wakeRequest, 1'b0);
        apb(1'b1, OFS_WAKE_FILTER, 32'h1);
        aMask[3] <= 1'b0; repeat (30) @(posedge clk); chk(wakeRequest, 1'b0);
        repeat (400) @(posedge clk); chk(wakeRequest, 1'b1);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_ext;
        t_wake;
        test_done;
    end
    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        test_done;
    end
endmodule
